// ### core/etc_pkg.sv
package etc_pkg;

   // Timing of the management clock
   localparam int CLK_NS            = 4;
   localparam int MDC_HIGH_MIN_NS   = 160;
   localparam int MDC_PERIOD_MIN_NS = 400;
   localparam int HALF_A = (MDC_HIGH_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int HALF_B = (MDC_PERIOD_MIN_NS / 2 + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0] MDC_HALF_CYC = 6'(HALF_A > HALF_B ? HALF_A : HALF_B);

   // Strap capture delay after reset release
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // Frame layout
   localparam logic [31:0] PREAMBLE  = 32'hFFFFFFFF;
   localparam logic [5:0]  PRE_MIN   = 6'h20;
   localparam logic [1:0]  SOF       = 2'h1;
   localparam logic [1:0]  OP_READ   = 2'h2;
   localparam logic [1:0]  OP_WRITE  = 2'h1;
   localparam logic [1:0]  TA_WRITE  = 2'h2;
   localparam logic [6:0]  BIT_TA    = 7'h2E;
   localparam logic [6:0]  BIT_DATA  = 7'h30;
   localparam logic [6:0]  BIT_LAST  = 7'h3F;
   localparam logic [4:0]  HDR_LAST  = 5'h0C;
   localparam logic [4:0]  RD_TA     = 5'h01;
   localparam logic [4:0]  RD_END    = 5'h12;
   localparam logic [4:0]  WR_LAST   = 5'h11;

   // Bus register offsets
   localparam logic [7:0] A_CFG      = 8'h00;
   localparam logic [7:0] A_CTRL     = 8'h04;
   localparam logic [7:0] A_DATA     = 8'h08;
   localparam logic [7:0] A_STAT     = 8'h0C;
   localparam logic [7:0] A_PHY_CTRL = 8'h10;

   // Local PHY register file
   localparam logic [4:0]  PR_CTRL  = 5'h00;
   localparam logic [4:0]  PR_STAT  = 5'h01;
   localparam logic [15:0] PHY_STAT_VAL = 16'h7809;
   localparam int B_SPD_LO = 13;
   localparam int B_ANEG   = 12;
   localparam int B_ISO    = 10;
   localparam int B_DUPLEX = 8;
   localparam int B_SPD_HI = 6;

   // Interface select codes
   localparam logic [1:0] IF_RGMII    = 2'h0;
   localparam logic [1:0] IF_RGMII_DL = 2'h1;
   localparam logic [1:0] IF_MII      = 2'h3;

   typedef struct packed {
      logic       role;
      logic [1:0] if_sel;
      logic [1:0] speed;
      logic [1:0] addr;
      logic       iso;
      logic       aneg;
      logic       duplex;
   } etc_strap_s;

   typedef struct packed {
      logic       valid;
      logic       is_mac;
      logic       rgmii;
      logic       rx_delay;
      logic       mii;
      logic [1:0] speed;
      logic [4:0] mgmt_addr;
      logic       isolate;
      logic       aneg;
      logic       full_duplex;
   } etc_cfg_s;

   typedef enum logic [1:0] {
      P_PRE = 2'b00,
      P_HDR = 2'b01,
      P_RD  = 2'b10,
      P_WR  = 2'b11
   } etc_phy_e;

endpackage

// ### core/etc_top.sv
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
module etc_top (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              reset,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp,
   // Configuration straps
   input  wire etc_pkg::etc_strap_s straps,
   output etc_pkg::etc_cfg_s      cfg,
   // Management clock pin
   input  wire logic              mdc_in,
   output logic                   mdc_out,
   output logic                   mdc_oe,
   // Management data pin
   input  wire logic              mdio_in,
   output logic                   mdio_out,
   output logic                   mdio_oe,
   // Host transmit side and isolation
   input  wire logic              host_transmit_enable,
   input  wire logic [3:0]        host_transmit_data,
   output logic                   tx_enable_q,
   output logic [3:0]             tx_data_q,
   output logic                   host_rx_oe
);

   typedef struct packed {
      logic [1:0]          rst_cnt;
      logic                captured;
      etc_pkg::etc_strap_s strap_m;
      etc_pkg::etc_strap_s strap_s;
      etc_pkg::etc_strap_s strap;
      logic [15:0]         phy_ctrl;
      logic [4:0]          tx_m;
      logic [4:0]          tx_s;
      logic [4:0]          tx_q;
      logic                mdc_m;
      logic                mdc_s;
      logic                mdc_p;
      logic                dio_m;
      logic                dio_s;
      logic [5:0]          div;
      logic                mdc_o;
      logic [6:0]          bit_n;
      logic [63:0]         sh;
      logic                busy;
      logic                done;
      logic                st_rd;
      logic [4:0]          st_pa;
      logic [4:0]          st_ra;
      logic [15:0]         wdata;
      logic [15:0]         rdata;
      logic                st_o;
      logic                st_oe;
      etc_pkg::etc_phy_e   pst;
      logic [5:0]          ones;
      logic [4:0]          pcnt;
      logic [12:0]         hdr;
      logic [15:0]         psh;
      logic                p_o;
      logic                p_oe;
      logic                ph_wr;
      logic [7:0]          ph_addr;
      logic [31:0]         rd_q;
   } etc_state_s;

   etc_state_s s;
   etc_state_s next_s;

   // Local PHY register read; reg0 is the live control word, reg1 a fixed
   // status pattern, and every other register reads as zero
   function automatic logic [15:0] phy_reg(input logic [4:0] ra, input logic [15:0] ctrl);
      logic [15:0] v;
      v = 16'h0000;
      if (ra == etc_pkg::PR_CTRL) begin
         v = ctrl;
      end else if (ra == etc_pkg::PR_STAT) begin
         v = etc_pkg::PHY_STAT_VAL;
      end
      return v;
   endfunction

   // Strap decode; PHY-only fields forced to zero in MAC role
   always_comb begin
      cfg.valid       = s.captured;
      cfg.is_mac      = s.strap.role;
      cfg.rgmii       = s.strap.if_sel == etc_pkg::IF_RGMII ||
                        s.strap.if_sel == etc_pkg::IF_RGMII_DL;
      cfg.rx_delay    = s.strap.if_sel == etc_pkg::IF_RGMII_DL;
      cfg.mii         = s.strap.if_sel == etc_pkg::IF_MII;
      cfg.speed       = s.strap.role ? 2'h0 : s.strap.speed;
      cfg.mgmt_addr   = s.strap.role ? 5'h00 : {s.strap.addr, 3'h0};
      cfg.isolate     = !s.strap.role && s.phy_ctrl[etc_pkg::B_ISO];
      cfg.aneg        = !s.strap.role && s.phy_ctrl[etc_pkg::B_ANEG];
      cfg.full_duplex = !s.strap.role && s.phy_ctrl[etc_pkg::B_DUPLEX];
   end

   // Next-state logic for the whole block
   always_comb begin
      logic        acc;
      logic        rise;
      logic        fall;
      logic        is_phy;
      logic [63:0] frame;
      logic [12:0] h;
      logic [15:0] w;
      acc    = hsel && htrans[1] && hready;
      rise   = s.mdc_s && !s.mdc_p;
      fall   = !s.mdc_s && s.mdc_p;
      is_phy = s.captured && !s.strap.role;
      frame  = 64'h0;
      h      = {s.hdr[11:0], s.dio_s};
      w      = {s.psh[14:0], s.dio_s};
      next_s = s;

      // Two-stage synchronisers for the straps, host transmit and management pins
      next_s.strap_m = straps;
      next_s.strap_s = s.strap_m;
      next_s.tx_m    = {host_transmit_enable, host_transmit_data};
      next_s.tx_s    = s.tx_m;
      next_s.mdc_m   = mdc_in;
      next_s.mdc_s   = s.mdc_m;
      next_s.mdc_p   = s.mdc_s;
      next_s.dio_m   = mdio_in;
      next_s.dio_s   = s.dio_m;

      // Straps caught a settled interval after reset release
      // The settle count lets the strap synchronisers fill before the capture
      if (!s.captured) begin
         next_s.rst_cnt = s.rst_cnt + 2'h1;
         if (s.rst_cnt == etc_pkg::STRAP_SETTLE) begin
            next_s.captured = 1'b1;
            next_s.strap    = s.strap_s;
            next_s.phy_ctrl = 16'h0000;
            if (!s.strap_s.role) begin
               next_s.phy_ctrl[etc_pkg::B_SPD_LO] = s.strap_s.speed[0];
               next_s.phy_ctrl[etc_pkg::B_SPD_HI] = s.strap_s.speed[1];
               next_s.phy_ctrl[etc_pkg::B_ANEG]   = s.strap_s.aneg;
               next_s.phy_ctrl[etc_pkg::B_ISO]    = s.strap_s.iso;
               next_s.phy_ctrl[etc_pkg::B_DUPLEX] = s.strap_s.duplex;
            end
         end
      end

      // Isolated PHY drops host transmit inputs
      // The synchronised copy is still kept, so leaving isolation resumes cleanly
      if (is_phy && !s.phy_ctrl[etc_pkg::B_ISO]) begin
         next_s.tx_q = s.tx_s;
      end else begin
         next_s.tx_q = 5'h00;
      end

      // Bus address phase; read data prepared for the data phase
      // Only the low address byte is decoded, so the map repeats upward
      next_s.ph_wr = acc && hwrite;
      next_s.ph_addr = haddr[7:0];
      if (acc && !hwrite) begin
         if (haddr[7:0] == etc_pkg::A_CFG) begin
            next_s.rd_q = {17'h0, cfg};
         end else if (haddr[7:0] == etc_pkg::A_CTRL) begin
            next_s.rd_q = {20'h0, s.st_ra, s.st_pa, s.st_rd, 1'b0};
         end else if (haddr[7:0] == etc_pkg::A_DATA) begin
            next_s.rd_q = {16'h0, s.rdata};
         end else if (haddr[7:0] == etc_pkg::A_STAT) begin
            next_s.rd_q = {30'h0, s.done, s.busy};
         end else if (haddr[7:0] == etc_pkg::A_PHY_CTRL) begin
            next_s.rd_q = {16'h0, s.phy_ctrl};
         end else begin
            next_s.rd_q = 32'h0;
         end
      end

      // Bus data phase writes; a refused start (busy, PHY role, straps not
      // yet caught) is dropped silently, so software polls the status word
      if (s.ph_wr) begin
         if (s.ph_addr == etc_pkg::A_CTRL) begin
            if (hwdata[0] && !s.busy && s.captured && s.strap.role) begin
               next_s.busy  = 1'b1;
               next_s.st_rd = hwdata[1];
               next_s.st_pa = hwdata[6:2];
               next_s.st_ra = hwdata[11:7];
               frame = {etc_pkg::PREAMBLE, etc_pkg::SOF,
                        hwdata[1] ? etc_pkg::OP_READ : etc_pkg::OP_WRITE,
                        hwdata[6:2], hwdata[11:7],
                        hwdata[1] ? 2'h3 : etc_pkg::TA_WRITE,
                        hwdata[1] ? 16'hFFFF : s.wdata};
               next_s.sh    = frame;
               next_s.bit_n = 7'h00;
               next_s.div   = 6'h00;
               next_s.mdc_o = 1'b0;
               next_s.st_o  = frame[63];
               next_s.st_oe = 1'b1;
            end
         end else if (s.ph_addr == etc_pkg::A_DATA) begin
            next_s.wdata = hwdata[15:0];
         end else if (s.ph_addr == etc_pkg::A_STAT) begin
            if (hwdata[1]) begin
               next_s.done = 1'b0;
            end
         end else if (s.ph_addr == etc_pkg::A_PHY_CTRL) begin
            next_s.phy_ctrl = hwdata[15:0];
         end
      end

      // Station: MDC from a divider, bits change on the falling edge
      // Runs after the bus writes so a frame end beats a done clear in one cycle
      // The clock idles low between frames; each half is a whole divider span
      if (s.busy) begin
         if (s.div == etc_pkg::MDC_HALF_CYC - 6'h01) begin
            next_s.div   = 6'h00;
            next_s.mdc_o = !s.mdc_o;
            if (!s.mdc_o) begin
               // Rising edge: PHY data has been stable a half period
               if (s.st_rd && s.bit_n >= etc_pkg::BIT_DATA) begin
                  next_s.rdata = {s.rdata[14:0], s.dio_s};
               end
            end else if (s.bit_n == etc_pkg::BIT_LAST) begin
               next_s.busy  = 1'b0;
               next_s.done  = 1'b1;
               next_s.st_oe = 1'b0;
            end else begin
               next_s.bit_n = s.bit_n + 7'h01;
               next_s.sh    = {s.sh[62:0], 1'b0};
               next_s.st_o  = s.sh[62];
               if (s.st_rd && s.bit_n + 7'h01 >= etc_pkg::BIT_TA) begin
                  next_s.st_oe = 1'b0;
               end
            end
         end else begin
            next_s.div = s.div + 6'h01;
         end
      end

      // Managed PHY: decode frames on the synchronised MDC
      // Pin edges are seen three cycles late, which the slow MDC easily absorbs;
      // a frame the station abandons leaves the decoder waiting for more edges
      // MDIO writes to reg0 sit after the bus writes, so they win a tie
      if (!is_phy) begin
         next_s.pst  = etc_pkg::P_PRE;
         next_s.ones = 6'h00;
         next_s.p_oe = 1'b0;
      end else begin
         case (s.pst)
            etc_pkg::P_PRE: begin
               if (rise) begin
                  if (s.dio_s) begin
                     if (s.ones != 6'h3F) begin
                        next_s.ones = s.ones + 6'h01;
                     end
                  end else begin
                     next_s.ones = 6'h00;
                     if (s.ones >= etc_pkg::PRE_MIN) begin
                        next_s.pst  = etc_pkg::P_HDR;
                        next_s.pcnt = 5'h00;
                     end
                  end
               end
            end
            etc_pkg::P_HDR: begin
               if (rise) begin
                  next_s.hdr  = h;
                  next_s.pcnt = s.pcnt + 5'h01;
                  if (s.pcnt == etc_pkg::HDR_LAST) begin
                     next_s.pcnt = 5'h00;
                     next_s.pst  = etc_pkg::P_PRE;
                     if (h[12] && h[9:5] == cfg.mgmt_addr) begin
                        if (h[11:10] == etc_pkg::OP_READ) begin
                           next_s.pst = etc_pkg::P_RD;
                           next_s.psh = phy_reg(h[4:0], s.phy_ctrl);
                        end else if (h[11:10] == etc_pkg::OP_WRITE) begin
                           next_s.pst = etc_pkg::P_WR;
                        end
                     end
                  end
               end
            end
            etc_pkg::P_RD: begin
               if (fall) begin
                  next_s.pcnt = s.pcnt + 5'h01;
                  if (s.pcnt == etc_pkg::RD_TA) begin
                     next_s.p_oe = 1'b1;
                     next_s.p_o  = 1'b0;
                  end else if (s.pcnt == etc_pkg::RD_END) begin
                     next_s.p_oe = 1'b0;
                     next_s.pst  = etc_pkg::P_PRE;
                  end else if (s.pcnt > etc_pkg::RD_TA) begin
                     next_s.p_o = s.psh[15];
                     next_s.psh = {s.psh[14:0], 1'b0};
                  end
               end
            end
            etc_pkg::P_WR: begin
               if (rise) begin
                  next_s.psh  = w;
                  next_s.pcnt = s.pcnt + 5'h01;
                  if (s.pcnt == etc_pkg::WR_LAST) begin
                     next_s.pst = etc_pkg::P_PRE;
                     if (s.hdr[4:0] == etc_pkg::PR_CTRL) begin
                        next_s.phy_ctrl = w;
                     end
                  end
               end
            end
            default: begin
               next_s.pst = etc_pkg::P_PRE;
            end
         endcase
      end
   end

   // State register, synchronous reset
   // Reset clears the capture flag, so straps are caught again on release
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Pin and bus outputs
   // Zero wait states: every access completes in its first data phase
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign hrdata      = s.rd_q;
   assign mdc_out     = s.mdc_o;
   assign mdc_oe      = s.captured && s.strap.role;
   // Data line follows the role: station bits or the managed answer
   assign mdio_out    = s.strap.role ? s.st_o : s.p_o;
   assign mdio_oe     = s.captured && (s.strap.role ? s.st_oe : s.p_oe);
   assign tx_enable_q = s.tx_q[4];
   assign tx_data_q   = s.tx_q[3:0];
   // Receive-side outputs float while isolated
   assign host_rx_oe  = s.captured && !s.strap.role &&
                        !s.phy_ctrl[etc_pkg::B_ISO];

endmodule

// ### test/etc_mgmt_partner.sv
`timescale 1ns/100ps
// Far party: a managed PHY answering the block's station, plus a station task
module etc_mgmt_partner #(
   parameter logic [15:0] RDATA = 16'hA5C3
) (
   // Far-side pins
   input  wire logic mdc,
   input  wire logic mdio,
   output logic      mdc_drv,
   output logic      mdio_drv,
   output logic      mdio_en
);
   logic [63:0] sh;
   logic [63:0] last;
   logic [63:0] f;
   logic [6:0]  n;
   logic        rd_op, p_en, p_d, s_en, s_d;

   // One line for both roles; only one of them is active at a time
   assign mdio_en  = p_en | s_en;
   assign mdio_drv = s_en ? s_d : p_d;

   initial begin
      {n, rd_op, p_en, p_d, s_en, s_d, mdc_drv} = '0;
   end

   // Managed PHY: bits enter on the rise; a 64-bit frame wraps the count
   always @(posedge mdc) begin
      sh = {sh[62:0], mdio};
      n = n + 7'h01;
      if (n == 7'h24) begin
         rd_op = (sh[3:0] == 4'h6);
      end
      if (n == 7'h40) begin
         last = sh;
         n = 7'h00;
      end
   end

   // Read answer leaves on the fall, so it is steady across the next rise
   always @(negedge mdc) begin
      if (rd_op && n == 7'h2F) begin
         p_en = 1'b1;
         p_d = 1'b0;
      end else if (rd_op && n >= 7'h30) begin
         p_d = RDATA[7'h3F - n];
      end else if (n == 7'h00) begin
         p_en = 1'b0;
         rd_op = 1'b0;
      end
   end

   // Station: runs at the bench link rate, faster than the pin minimum
   // to keep the run short; the clock stands low between frames
   task frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
              input logic [15:0] wd, output logic [16:0] rv);
      f = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
      rv = '0;
      #1.3;
      for (int i = 0; i < 64; i++) begin
         s_en = !(op == 2'h2 && i >= 46);
         s_d = f[63 - i];
         #24 mdc_drv = 1'b1;
         if (i >= 47) begin
            rv = {rv[15:0], mdio};
         end
         #24 mdc_drv = 1'b0;
      end
      s_en = 1'b0;
   endtask
endmodule

// ### test/etc_monitor.sv
`timescale 1ns/100ps
// Pin-level checks on strap decode, the station clock and isolation
module etc_monitor (
   // Clock and reset
   input wire logic               ref_clk,
   input wire logic               reset,
   // Bus response
   input wire logic               hreadyout,
   input wire logic               hresp,
   // Straps and decoded settings
   input wire etc_pkg::etc_strap_s straps,
   input wire etc_pkg::etc_cfg_s   cfg,
   // Management pins
   input wire logic               mdc_out,
   input wire logic               mdc_oe,
   input wire logic               mdio_out,
   input wire logic               mdio_oe,
   // Host transmit path
   input wire logic               host_transmit_enable,
   input wire logic               tx_enable_q,
   input wire logic [3:0]         tx_data_q,
   input wire logic               host_rx_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   logic       last_mdc;
   logic [7:0] run;
   logic [7:0] hi_len;

   // Phase lengths of the clock; saturate so idle gaps never look short
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         last_mdc <= 1'b0;
         run      <= 8'hFF;
         hi_len   <= 8'hFF;
      end else begin
         last_mdc <= mdc_out;
         if (mdc_out != last_mdc) begin
            run <= 8'h00;
         end else if (run != 8'hFF) begin
            run <= run + 8'h01;
         end
         if (last_mdc && !mdc_out) begin
            hi_len <= run;
         end
      end
   end

   sequence s_iso;
      (cfg.valid && cfg.isolate) [*4];
   endsequence
   sequence s_open;
      (cfg.valid && !cfg.is_mac && !cfg.isolate) [*4];
   endsequence

   property p_bus_okay; hreadyout && !hresp; endproperty
   property p_clk_owner; cfg.valid |-> mdc_oe == cfg.is_mac; endproperty
   property p_clk_high; $fell(mdc_out) |-> run >= 8'h27; endproperty
   property p_clk_low; $rose(mdc_out) |-> run >= 8'h27; endproperty
   property p_clk_period;
      $rose(mdc_out) |-> {1'b0, run} + {1'b0, hi_len} >= 9'h062;
   endproperty
   property p_role; cfg.valid |-> cfg.is_mac == straps.role; endproperty
   property p_if;
      cfg.valid |-> {cfg.rgmii, cfg.rx_delay, cfg.mii} ==
         {!straps.if_sel[1], straps.if_sel == 2'h1, straps.if_sel == 2'h3};
   endproperty
   property p_mac_ignore;
      cfg.valid && cfg.is_mac |-> cfg.mgmt_addr == 5'h00 && !host_rx_oe;
   endproperty
   property p_phy_addr;
      cfg.valid && !cfg.is_mac |-> cfg.mgmt_addr == {straps.addr, 3'h0};
   endproperty
   property p_iso_rx;
      host_rx_oe == (cfg.valid && !cfg.is_mac && !cfg.isolate);
   endproperty
   property p_iso_tx; s_iso |-> !tx_enable_q && tx_data_q == 4'h0; endproperty
   property p_tx_pass; s_open |-> tx_enable_q == $past(host_transmit_enable, 3); endproperty
   property p_cmd_fall;
      mdc_oe && mdio_oe && $past(mdio_oe) && $changed(mdio_out) |-> $fell(mdc_out);
   endproperty
   property p_ta_zero; !mdc_oe && $rose(mdio_oe) |-> !mdio_out; endproperty

   a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
   a_clk_owner: assert property (p_clk_owner) else $error("clock drive vs role");
   a_clk_high: assert property (p_clk_high) else $error("clock high too short");
   a_clk_low: assert property (p_clk_low) else $error("clock low too short");
   a_clk_period: assert property (p_clk_period) else $error("clock period short");
   a_role: assert property (p_role) else $error("role decode wrong");
   a_if: assert property (p_if) else $error("interface decode wrong");
   a_mac_ignore: assert property (p_mac_ignore) else $error("phy strap in mac role");
   a_phy_addr: assert property (p_phy_addr) else $error("address decode wrong");
   a_iso_rx: assert property (p_iso_rx) else $error("receive drive vs isolate");
   a_iso_tx: assert property (p_iso_tx) else $error("transmit passed isolated");
   a_tx_pass: assert property (p_tx_pass) else $error("transmit copy wrong");
   a_cmd_fall: assert property (p_cmd_fall) else $error("command bit off clock fall");
   a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");
endmodule

bind etc_top etc_monitor i_mon (
   .ref_clk, .reset, .hreadyout, .hresp, .straps, .cfg, .mdc_out, .mdc_oe, .mdio_out,
   .mdio_oe, .host_transmit_enable, .tx_enable_q, .tx_data_q, .host_rx_oe
);

// ### test/etc_tb_top.sv
`timescale 1ns/100ps
// Strap table, then station frames in both roles and isolation
module etc_tb_top;
   logic                ref_clk, reset, hsel, hwrite, hreadyout, hresp;
   logic [31:0]         haddr, hwdata, hrdata, rd;
   logic [1:0]          htrans;
   logic [2:0]          hsize;
   logic                mdc_out, mdc_oe, mdio_out, mdio_oe, p_mdc, p_d, p_en;
   logic                host_transmit_enable, tx_enable_q, host_rx_oe;
   logic [3:0]          host_transmit_data, tx_data_q;
   logic [16:0]         sr;
   logic [24:0]         rows [7];
   etc_pkg::etc_strap_s straps;
   etc_pkg::etc_cfg_s   cfg;
   int                  mismatches, check_count;
   // Pin levels; the data line has a pull-up when nobody drives
   wire                 mdc_ln  = mdc_oe ? mdc_out : p_mdc;
   wire                 mdio_ln = mdio_oe ? mdio_out : (p_en ? p_d : 1'b1);
   wire                 mdc_far = mdc_oe & mdc_out;

   etc_top i_dut (
      .ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .straps, .cfg,
      .mdc_in(mdc_ln), .mdc_out, .mdc_oe, .mdio_in(mdio_ln), .mdio_out, .mdio_oe,
      .host_transmit_enable, .host_transmit_data, .tx_enable_q, .tx_data_q, .host_rx_oe
   );
   etc_mgmt_partner i_far (
      .mdc(mdc_far), .mdio(mdio_ln), .mdc_drv(p_mdc), .mdio_drv(p_d), .mdio_en(p_en)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One single transfer; waits on ready, no assumed latency
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
   endtask

   // Straps only move under reset, as on a real board
   task reset_to(input logic [9:0] s);
      reset <= 1'b1;
      straps <= etc_pkg::etc_strap_s'(s);
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (5) @(posedge ref_clk);
   endtask

   task wait_done;
      for (int k = 0; k < 3000; k++) begin
         bus(1'b0, etc_pkg::A_STAT, 32'h0);
         if (rd[1] === 1'b1) break;
      end
      chk("done", 32'h1, {31'h0, rd[1]});
      bus(1'b1, etc_pkg::A_STAT, 32'h2);
   endtask

   task report_and_stop;
      if (mismatches == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard, well past the longest expected run
   initial begin
      #300000;
      mismatches++;
      report_and_stop;
   end

   initial begin
      {reset, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 69'h0};
      hsize = 3'h2;
      straps = '0;
      host_transmit_enable = 1'b0;
      host_transmit_data = 4'h0;
      mismatches = 0;
      check_count = 0;
      // Strap word beside the decoded settings it must give
      rows = '{{10'h000, 15'h5000}, {10'h0AF, 15'h5947}, {10'h1D2, 15'h4682},
               {10'h039, 15'h51C1}, {10'h15E, 15'h42C6}, {10'h2DF, 15'h7800},
               {10'h384, 15'h6400}};
      foreach (rows[i]) begin
         reset_to(rows[i][24:15]);
         chk("cfg pins", 32'(rows[i][14:0]), 32'(cfg));
         bus(1'b0, etc_pkg::A_CFG, 32'h0);
         chk("cfg reg", {17'h0, rows[i][14:0]}, rd);
      end
      // Station role: write frame, then read frame
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1'b1, etc_pkg::A_DATA, 32'h1234);
      bus(1'b1, etc_pkg::A_CTRL, {20'h0, 5'h05, 5'h1F, 1'b0, 1'b1});
      wait_done;
      chk("preamble", 32'hFFFFFFFF, i_far.last[63:32]);
      chk("wr frame", {2'h1, 2'h1, 5'h1F, 5'h05, 2'h2, 16'h1234}, i_far.last[31:0]);
      bus(1'b1, etc_pkg::A_CTRL, {20'h0, 5'h01, 5'h08, 1'b1, 1'b1});
      wait_done;
      chk("rd hdr", {18'h0, 2'h1, 2'h2, 5'h08, 5'h01}, {18'h0, i_far.last[31:18]});
      bus(1'b0, etc_pkg::A_DATA, 32'h0);
      chk("rd data", 32'h0000A5C3, rd);
      bus(1'b0, etc_pkg::A_CTRL, 32'h0);
      chk("ctrl echo", 32'h000000A2, rd);
      // Managed role at address 0x08
      reset_to(10'h00B);
      host_transmit_enable <= 1'b1;
      host_transmit_data <= 4'hA;
      repeat (6) @(posedge ref_clk);
      chk("tx pass", 32'h1A, {27'h0, tx_enable_q, tx_data_q});
      i_far.frame(2'h2, 5'h08, 5'h01, 16'h0, sr);
      chk("phy stat", 32'h7809, {15'h0, sr});
      i_far.frame(2'h2, 5'h08, 5'h00, 16'h0, sr);
      chk("phy ctrl", 32'h1100, {15'h0, sr});
      i_far.frame(2'h2, 5'h10, 5'h01, 16'h0, sr);
      chk("other addr", 32'h1FFFF, {15'h0, sr});
      i_far.frame(2'h1, 5'h08, 5'h00, 16'h0400, sr);
      repeat (8) @(posedge ref_clk);
      chk("isolated", 32'h40, {25'h0, cfg.isolate, host_rx_oe, tx_enable_q, tx_data_q});
      i_far.frame(2'h2, 5'h08, 5'h00, 16'h0, sr);
      chk("ctrl back", 32'h0400, {15'h0, sr});
      bus(1'b0, etc_pkg::A_PHY_CTRL, 32'h0);
      chk("ctrl reg", 32'h0400, rd);
      bus(1'b1, etc_pkg::A_PHY_CTRL, 32'h1100);
      repeat (4) @(posedge ref_clk);
      chk("rejoined", 32'h3A, {25'h0, cfg.isolate, host_rx_oe, tx_enable_q, tx_data_q});
      report_and_stop;
   end
endmodule
